// ---- rtl/hspf_defines.vh ----
// Constants for the host serial port framing block
`ifndef HSPF_DEFINES_VH
`define HSPF_DEFINES_VH
`define HSPF_WORD_BITS 16
`define HSPF_BYTE_BITS 8
`define HSPF_CNT_W 5
`define HSPF_CNT_ZERO 5'h00
`define HSPF_CNT_ONE 5'h01
`define HSPF_CNT_BYTE 5'h08
`define HSPF_CNT_WORD 5'h10
`define HSPF_WORD_ZERO 16'h0000
`define HSPF_MODE_SPI 1'b0
`define HSPF_MODE_I2C 1'b1
`endif

// ---- rtl/hspf_sync.v ----
// Two-flop synchroniser for a vector of pin inputs
module hspf_sync #(
    parameter WIDTH = 3
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            meta_q <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // hspf_sync

// ---- rtl/hspf_framing.v ----
// Host command port serial slave: word framing and chip-select handling
// Notes on behaviour
// - A paused serial clock, high or low, loses no received or pending state.
// - In SPI mode with chip select low, every 16 shifted bits become one word.
// - First output bit driven at later of chip-select fall or clock fall.
// - A frame whose clock count is not a multiple of 8 raises frame_error_out at select rise.
// - Several commands may share one chip-select low period.
// - Chip-select rise ends the sequence and resets framing logic.
// - In I2C operation the same pins serve the I2C side.
// - Port gives host access to memory and registers, SPI or I2C.
`include "hspf_defines.vh"
module hspf_framing (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire host_serial_clk_in,
    input wire host_chip_select_n_in,
    input wire host_serial_in,
    input wire host_mode_i2c_in,
    input wire [`HSPF_WORD_BITS-1:0] tx_word_in,
    output reg host_serial_out,
    output reg host_serial_oe_n_out,
    output reg [`HSPF_WORD_BITS-1:0] rx_word_out,
    output reg rx_word_valid_out,
    output reg tx_word_taken_out,
    output reg frame_error_out,
    output reg frame_end_out,
    output reg i2c_scl_out,
    output reg i2c_sda_out
);
    wire [2:0] pins_s;
    wire sclk_s;
    wire csn_s;
    wire din_s;
    reg sclk_q;
    reg csn_q;
    reg [`HSPF_CNT_W-1:0] cnt_q;
    reg [`HSPF_WORD_BITS-1:0] shift_q;
    reg [`HSPF_WORD_BITS-1:0] tx_q;
    reg bad_q;
    reg [1:0] tx_state_q;
    wire spi_csn;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_rise;
    wire cs_fall;
    wire [`HSPF_CNT_W-1:0] cnt_inc;
    wire bad_length;

    // Output side states
    localparam TX_IDLE = 2'b00;
    localparam TX_WAIT = 2'b01;
    localparam TX_SEND = 2'b10;

    // Edge finders shared by the clock and the select paths
    function hspf_rise;
        input now_v;
        input prev_v;
        begin
            hspf_rise = now_v & ~prev_v;
        end
    endfunction

    function hspf_fall;
        input now_v;
        input prev_v;
        begin
            hspf_fall = ~now_v & prev_v;
        end
    endfunction

    // Remaining bits of a word once its top bit is on the line
    function [`HSPF_WORD_BITS-1:0] hspf_rest;
        input [`HSPF_WORD_BITS-1:0] word_v;
        begin
            hspf_rest = {word_v[`HSPF_WORD_BITS-2:0], 1'b0};
        end
    endfunction

    hspf_sync #(.WIDTH(3)) u_sync (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({host_serial_clk_in, host_chip_select_n_in, host_serial_in}),
        .sync_out(pins_s)
    );
    assign sclk_s = pins_s[2];
    assign csn_s = pins_s[1];
    assign din_s = pins_s[0];
    // In I2C mode the SPI framing sees chip select as idle high
    assign spi_csn = csn_s | (host_mode_i2c_in == `HSPF_MODE_I2C);
    assign sclk_rise = hspf_rise(sclk_s, sclk_q);
    assign sclk_fall = hspf_fall(sclk_s, sclk_q);
    assign cs_rise = hspf_rise(spi_csn, csn_q);
    assign cs_fall = hspf_fall(spi_csn, csn_q);
    assign cnt_inc = cnt_q + `HSPF_CNT_ONE;
    // Only whole bytes or whole words end a frame cleanly
    assign bad_length = (cnt_q != `HSPF_CNT_ZERO) && (cnt_q != `HSPF_CNT_BYTE);

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            // Matches the synchroniser's reset level so no false edge follows reset
            sclk_q <= 1'b1;
            csn_q <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            csn_q <= spi_csn;
        end
    end

    // Pass-through of shared pins to the I2C side in I2C mode; both held high in SPI mode
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            i2c_scl_out <= 1'b1;
            i2c_sda_out <= 1'b1;
        end else begin
            i2c_scl_out <= sclk_s | ~host_mode_i2c_in;
            i2c_sda_out <= din_s | ~host_mode_i2c_in;
        end
    end

    // Framing state only moves on clock edges or select rise, so a stalled clock holds it
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cnt_q <= `HSPF_CNT_ZERO;
            shift_q <= `HSPF_WORD_ZERO;
            rx_word_out <= `HSPF_WORD_ZERO;
            rx_word_valid_out <= 1'b0;
            frame_error_out <= 1'b0;
            frame_end_out <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            rx_word_valid_out <= 1'b0;
            frame_error_out <= 1'b0;
            frame_end_out <= 1'b0;
            if (cs_rise) begin
                // Close of chip select returns framing to reset
                cnt_q <= `HSPF_CNT_ZERO;
                shift_q <= `HSPF_WORD_ZERO;
                frame_end_out <= 1'b1;
                frame_error_out <= bad_length | bad_q;
                bad_q <= 1'b0;
            end else if (!spi_csn && sclk_rise) begin
                shift_q <= {shift_q[`HSPF_WORD_BITS-2:0], din_s};
                if (cnt_inc == `HSPF_CNT_WORD) begin
                    // Counter wraps so back-to-back words stay framed
                    cnt_q <= `HSPF_CNT_ZERO;
                    rx_word_out <= {shift_q[`HSPF_WORD_BITS-2:0], din_s};
                    rx_word_valid_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_inc;
                end
            end
        end
    end

    // Output shifter: first bit goes out at the later of select fall and clock fall
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tx_state_q <= TX_IDLE;
            tx_q <= `HSPF_WORD_ZERO;
            tx_word_taken_out <= 1'b0;
            host_serial_out <= 1'b0;
            host_serial_oe_n_out <= 1'b1;
        end else begin
            tx_word_taken_out <= 1'b0;
            case (tx_state_q)
                TX_IDLE: begin
                    host_serial_oe_n_out <= 1'b1;
                    if (cs_fall && !sclk_s) begin
                        // Clock already low: chip-select fall is the later edge
                        tx_state_q <= TX_SEND;
                        tx_q <= hspf_rest(tx_word_in);
                        host_serial_out <= tx_word_in[`HSPF_WORD_BITS-1];
                        host_serial_oe_n_out <= 1'b0;
                        tx_word_taken_out <= 1'b1;
                    end else if (cs_fall) begin
                        // Clock high at select fall: first bit waits for its fall
                        tx_state_q <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (spi_csn) begin
                        // Select dropped before any clock: nothing was sent
                        tx_state_q <= TX_IDLE;
                    end else if (sclk_fall) begin
                        tx_state_q <= TX_SEND;
                        tx_q <= hspf_rest(tx_word_in);
                        host_serial_out <= tx_word_in[`HSPF_WORD_BITS-1];
                        host_serial_oe_n_out <= 1'b0;
                        tx_word_taken_out <= 1'b1;
                    end
                end
                TX_SEND: begin
                    if (spi_csn) begin
                        // Release the line as soon as select rises
                        host_serial_oe_n_out <= 1'b1;
                        tx_state_q <= TX_IDLE;
                    end else if (sclk_fall) begin
                        if (cnt_q == `HSPF_CNT_ZERO) begin
                            // Word boundary: fetch the next word to send
                            tx_q <= hspf_rest(tx_word_in);
                            host_serial_out <= tx_word_in[`HSPF_WORD_BITS-1];
                            tx_word_taken_out <= 1'b1;
                        end else begin
                            tx_q <= hspf_rest(tx_q);
                            host_serial_out <= tx_q[`HSPF_WORD_BITS-1];
                        end
                    end
                end
                default: begin
                    tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end
endmodule // hspf_framing

// ---- bench/hspf_props.sv ----
// Concurrent checks on the host serial framing ports
module hspf_props (
    input logic ref_clk_in, sys_rst_in, host_chip_select_n_in, host_mode_i2c_in,
    input logic host_serial_oe_n_out, rx_word_valid_out, tx_word_taken_out,
    input logic frame_error_out, frame_end_out, i2c_scl_out, i2c_sda_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Five cycles lets the select change pass the synchroniser
    sequence s_idle; host_chip_select_n_in [*5]; endsequence
    sequence s_spi; !host_mode_i2c_in [*4]; endsequence
    sequence s_i2c; host_mode_i2c_in [*4]; endsequence
    sequence s_rise; $rose(host_chip_select_n_in) && !host_mode_i2c_in; endsequence
    sequence s_on; $fell(host_serial_oe_n_out); endsequence
    a_oe_idle: assert property (s_idle |-> host_serial_oe_n_out) else $error("oe");
    a_idle_no_word: assert property (s_idle |-> !rx_word_valid_out) else $error("rx");
    a_end_rise: assert property (s_rise |-> ##[1:6] frame_end_out) else $error("end");
    a_end_once: assert property (frame_end_out |=> !frame_end_out) else $error("pulse");
    a_err_end: assert property (frame_error_out |-> frame_end_out) else $error("err");
    a_i2c_idle: assert property (s_spi |-> i2c_scl_out && i2c_sda_out) else $error("i2c");
    a_i2c_quiet: assert property (s_i2c |-> host_serial_oe_n_out) else $error("i2c oe");
    a_oe_sel: assert property (s_on |-> !host_chip_select_n_in) else $error("sel");
    a_first_bit: assert property (s_on |->
        tx_word_taken_out || $past(tx_word_taken_out)) else $error("tx");
endmodule // hspf_props
bind hspf_framing hspf_props chk_u (.*);

// ---- bench/hspf_host_model.sv ----
// Host master model driving the serial port pins
module hspf_host_model (
    output logic sclk_out = 0, cs_n_out = 1, din_out = 0,
    input logic dout_in
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic xfer(input int n, input logic [31:0] w, input int pause,
        output logic [31:0] r);
        r = 0;
        // Offset keeps link edges away from system clock edges
        #7 cs_n_out = 0;
        for (int i = 0; i < n; i++) begin
            din_out = w[n-1-i];
            #160 sclk_out = 1;
            if (i == pause) #2000;
            #160 r = {r[30:0], dout_in};
            sclk_out = 0;
        end
        #160 cs_n_out = 1;
        din_out = ~din_out;
        #200;
    endtask
endmodule // hspf_host_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the host serial framing block
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in = 0, sys_rst_in = 1, mode_q = 0, valid, fend, ferr;
    logic [15:0] tx_q = 0, rx;
    logic [31:0] r, w;
    wire sclk, cs_n, din, dout, oe_n;
    int miscompares = 0, n_compared = 0, cyc = 0, nerr = 0, nend = 0, k;
    logic [15:0] q[$];
    always #20 ref_clk_in = ~ref_clk_in;
    hspf_framing dut_u (.ref_clk_in, .sys_rst_in, .host_serial_clk_in(sclk),
        .host_chip_select_n_in(cs_n), .host_serial_in(din), .host_mode_i2c_in(mode_q),
        .tx_word_in(tx_q), .host_serial_out(dout), .host_serial_oe_n_out(oe_n),
        .rx_word_out(rx), .rx_word_valid_out(valid), .tx_word_taken_out(),
        .frame_error_out(ferr), .frame_end_out(fend), .i2c_scl_out(), .i2c_sda_out());
    // A released line reads as the inverse so late driving shows up
    hspf_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
        .dout_in(oe_n ? ~dout : dout));
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (valid === 1'b1) q.push_back(rx);
        nerr += (ferr === 1'b1);
        nend += (fend === 1'b1);
        if (cyc > 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic run(int n, int pause, logic err);
        int e0, d0;
        e0 = nerr;
        d0 = nend;
        q = {};
        w = $urandom;
        @(posedge ref_clk_in) tx_q <= $urandom;
        host_u.xfer(n, w, pause, r);
        repeat (10) @(posedge ref_clk_in);
        `CHK("error", err, nerr != e0)
        `CHK("words", mode_q ? 0 : n / 16, q.size())
        foreach (q[i]) `CHK("rx", w[n-1-16*i -: 16], q[i])
        if (!mode_q) `CHK("end", 1, nend - d0)
        if (!mode_q && n >= 16) `CHK("tx", tx_q, r[n-1 -: 16])
        $display("test done bits %0d", n);
    endtask
    initial begin
        void'($urandom(66));
        repeat (8) @(posedge ref_clk_in);
        sys_rst_in <= 0;
        repeat (3) @(posedge ref_clk_in);
        run(16, -1, 0);
        run(32, 7, 0);
        run(24, -1, 0);
        run(12, -1, 1);
        run(8, -1, 0);
        repeat (8) begin
            k = 1 + $urandom % 32;
            run(k, $urandom % k, (k % 8) != 0);
        end
        mode_q <= 1'b1;
        run(16, -1, 0);
        give_verdict();
    end
endmodule // tb_top
